// ==== include/idca_pkg.sv ====
// Package for the input data clock alignment block: register map,
// field positions, reset values, timing figures and carrier structs.
// Assumes one reference clock domain; each mclk cycle is one reference cycle.
package idca_pkg;

	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int REG_AW = 8;
	localparam int REG_DW = 8;

	////////////////////////////////////////////////////////////////////////
	// Register offsets.
	localparam logic [7:0] REG_DCLK_CTRL = 8'h02;
	localparam logic [7:0] REG_DCLK_DIV = 8'h03;
	localparam logic [7:0] REG_FINE_DELAY = 8'h04;
	localparam logic [7:0] REG_SHIFT = 8'h07;
	localparam logic [7:0] REG_MODE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h09;

	// Field positions.
	localparam int FINE_DIS_BIT = 4;
	localparam int EXTRA_DIV_LSB = 4;
	localparam int FINE_CODE_LSB = 4;
	localparam int SHIFT_LSB = 0;
	localparam int MODE_INTERP_LSB = 0;
	localparam int MODE_ZSTUFF_BIT = 2;
	localparam int MODE_ILEAVE_BIT = 3;
	localparam int STAT_LOG_LSB = 0;
	localparam int STAT_INVALID_BIT = 3;
	localparam int STAT_OVF_BIT = 4;
	localparam int STAT_LOCK_BIT = 5;

	// Reset values.
	localparam logic [7:0] RST_DCLK_CTRL = 8'h00;
	localparam logic [1:0] RST_EXTRA_DIV = 2'h0;
	localparam logic [3:0] RST_FINE_CODE = 4'h0;
	localparam logic [4:0] RST_SHIFT = 5'h00;
	localparam logic [3:0] RST_MODE = 4'h0;

	// Timing figures.
	localparam int FINE_STEP_PS = 183;
	localparam logic [2:0] MAX_DIV_LOG = 3'h5;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [REG_DW-1:0] wdata;
		logic wr;
		logic rd;
	} idca_reg_req_s;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} idca_word_s;

endpackage : idca_pkg

// ==== rtl/idca_align.sv ====
// Data clock generation and sync alignment for the converter input port.
// Assumes mclk is the reference clock: one mclk cycle per reference cycle.
// Pins sync_in and data_in come from outside and are synchronised here.
`timescale 1ns/1ps
import idca_pkg::*;

// Operation
// - Without sync, data clock phase against reference is undetermined.
// - Input words are captured on the rising edge of the data clock.
// - Any sync rate however slow is accepted.
// - After a valid sync edge, data is latched on the next reference edge.
// - A data clock rising edge coincides with that next reference edge.
// - At interpolation one there is no ambiguity and sync is unneeded.
// - A five-bit shift moves the capture window by whole reference cycles.
// - A four-bit code adds fine delay between reference and data clock.
// - A disable bit removes the fine delay, leaving the default path.
// - Fine delay grows linearly from 0000 to 1111, about 183 ps a step.
// - Dual port divisor is the interpolation, doubled with zero stuffing.
// - Interleaved divisor is half interpolation, or equal with stuffing.
// - Extra divider codes 00, 01, 10, 11 divide by 1, 2, 4, 1.
// - The combined divisor never exceeds 32 reference cycles.
module idca_align (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Register port.
	input wire idca_pkg::idca_reg_req_s reg_req,
	output logic [idca_pkg::REG_DW-1:0] reg_rdata,
	// Link from the data source.
	input wire logic sync_in,
	input wire logic [idca_pkg::DATA_W-1:0] data_in,
	output logic data_clock_out,
	output logic [4:0] fine_delay_taps,
	// Captured words towards the converter.
	output idca_pkg::idca_word_s sample_out,
	input wire logic sample_ready
);
	import idca_pkg::*;

	typedef struct packed {
		logic sync_m1;
		logic sync_m2;
		logic sync_d;
		logic sync_d2;
		logic [DATA_W-1:0] data_m1;
		logic [DATA_W-1:0] data_m2;
		logic [4:0] cnt;
		logic dclk;
		logic [4:0] taps;
		logic fine_dis;
		logic [1:0] extra_div;
		logic [3:0] fine_code;
		logic [4:0] shift;
		logic [3:0] mode;
		logic ovf;
		logic locked;
		logic [REG_DW-1:0] rdata;
	} idca_state_s;

	idca_state_s st_reg;
	idca_state_s st_next;

	logic sync_rise;
	logic invalid;
	logic [2:0] div_log;
	logic [4:0] div_mask;
	logic [4:0] half;
	logic cap;
	logic fifo_in_ready;
	logic sync_pend;
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;
	logic [REG_DW-1:0] status;

	////////////////////////////////////////////////////////////////////////
	// Divisor from mode fields; returns log2 and flags the invalid mode.
	function automatic logic [3:0] calc_log(input logic [3:0] mode,
			input logic [1:0] xdiv);
		logic [2:0] ilog;
		logic [2:0] base;
		logic [2:0] xlog;
		logic [2:0] sum;
		logic bad;
		ilog = {1'b0, mode[MODE_INTERP_LSB +: 2]};
		bad = 1'b0;
		if (!mode[MODE_ILEAVE_BIT]) begin
			base = ilog + {2'b00, mode[MODE_ZSTUFF_BIT]};
		end else if (mode[MODE_ZSTUFF_BIT]) begin
			base = ilog;
		end else if (ilog == 3'h0) begin
			base = 3'h0;
			bad = 1'b1;
		end else begin
			base = ilog - 3'h1;
		end
		unique case (xdiv)
			2'h1: xlog = 3'h1;
			2'h2: xlog = 3'h2;
			2'h0, 2'h3: xlog = 3'h0;
		endcase
		sum = base + xlog;
		if (sum > MAX_DIV_LOG) begin
			sum = MAX_DIV_LOG;
		end
		return {bad, sum};
	endfunction : calc_log

	////////////////////////////////////////////////////////////////////////
	// Only the second sync flop and its delayed copies feed the edge detect.
	// The edge is acted on one cycle after it is first seen, so that the
	// data clock can be pulled low beforehand and shows a rise whenever the mode is valid and the divisor is above one.
	assign sync_pend = st_reg.sync_m2 & ~st_reg.sync_d;
	assign sync_rise = st_reg.sync_d & ~st_reg.sync_d2;
	assign {invalid, div_log} = calc_log(st_reg.mode, st_reg.extra_div);
	assign div_mask = 5'((6'h01 << div_log) - 6'h01);
	assign half = 5'((6'h01 << div_log) >> 1);
	// Capture on the data clock rising phase, moved by the shift field.
	assign cap = ~invalid & (st_reg.cnt == (st_reg.shift & div_mask));

	assign status = {2'b00, st_reg.locked, st_reg.ovf, invalid, div_log};

	always_comb begin
		logic [4:0] cnt_n;
		cnt_n = 5'h00;
		st_next = st_reg;
		st_next.sync_m1 = sync_in;
		st_next.sync_m2 = st_reg.sync_m1;
		st_next.sync_d = st_reg.sync_m2;
		st_next.sync_d2 = st_reg.sync_d;
		st_next.data_m1 = data_in;
		st_next.data_m2 = st_reg.data_m1;
		st_next.rdata = '0;

		// Any sync rate is fine: a slow or absent sync just leaves the
		// divider free running. At 1x the mask is zero so realigning is
		// harmless; the phase was never ambiguous there.
		if (sync_rise) begin
			cnt_n = 5'h00;
		end else begin
			cnt_n = (st_reg.cnt + 5'h01) & div_mask;
		end
		st_next.cnt = cnt_n;
		// Rising edge lands on the reference edge right after sync.
		if (invalid) begin
			st_next.dclk = 1'b0;
		end else if (div_mask == 5'h00) begin
			st_next.dclk = 1'b1;
		end else if (sync_pend) begin
			st_next.dclk = 1'b0;
		end else begin
			st_next.dclk = (cnt_n < half);
		end
		if (st_reg.fine_dis) begin
			st_next.taps = 5'h00;
		end else begin
			st_next.taps = {1'b0, st_reg.fine_code} + 5'h01;
		end
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				REG_DCLK_CTRL: st_next.fine_dis = reg_req.wdata[FINE_DIS_BIT];
				REG_DCLK_DIV:
					st_next.extra_div = reg_req.wdata[EXTRA_DIV_LSB +: 2];
				REG_FINE_DELAY:
					st_next.fine_code = reg_req.wdata[FINE_CODE_LSB +: 4];
				REG_SHIFT: st_next.shift = reg_req.wdata[SHIFT_LSB +: 5];
				REG_MODE: begin
					st_next.mode = reg_req.wdata[3:0];
					st_next.locked = 1'b0;
				end
				REG_STATUS: begin
					if (reg_req.wdata[STAT_OVF_BIT]) begin
						st_next.ovf = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// A word lost in the same cycle as the clear still sets the flag.
		if (cap & ~fifo_in_ready) begin
			st_next.ovf = 1'b1;
		end
		// A sync edge beside a mode write still locks: the set wins.
		if (sync_rise & ~invalid) begin
			st_next.locked = 1'b1;
		end

		if (reg_req.rd) begin
			unique case (reg_req.addr)
				REG_DCLK_CTRL:
					st_next.rdata = 8'(st_reg.fine_dis) << FINE_DIS_BIT;
				REG_DCLK_DIV:
					st_next.rdata = 8'(st_reg.extra_div) << EXTRA_DIV_LSB;
				REG_FINE_DELAY:
					st_next.rdata = 8'(st_reg.fine_code) << FINE_CODE_LSB;
				REG_SHIFT: st_next.rdata = 8'(st_reg.shift) << SHIFT_LSB;
				REG_MODE: st_next.rdata = {4'h0, st_reg.mode};
				REG_STATUS: st_next.rdata = status;
				default: st_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.fine_dis <= RST_DCLK_CTRL[FINE_DIS_BIT];
			st_reg.extra_div <= RST_EXTRA_DIV;
			st_reg.fine_code <= RST_FINE_CODE;
			st_reg.shift <= RST_SHIFT;
			st_reg.mode <= RST_MODE;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The FIFO absorbs converter stalls; a full FIFO drops and flags.
	idca_fifo #(
		.W(DATA_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.nrst(nrst),
		.in_valid(cap),
		.in_data(st_reg.data_m2),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(sample_ready)
	);

	assign sample_out = '{valid: fifo_out_valid, data: fifo_out_data};

	assign data_clock_out = st_reg.dclk;
	assign fine_delay_taps = st_reg.taps;
	assign reg_rdata = st_reg.rdata;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_sync_valid;
		sync_rise && !invalid && !reg_req.wr;
	endsequence

	sequence s_quiet3;
		(!sync_rise && !reg_req.wr) [*3];
	endsequence

	a_sync_realign: assert property (
		s_sync_valid |=> st_reg.cnt == 5'h00)
		else $error("divider phase not reset by sync");

	a_sync_latch_next: assert property (
		(s_sync_valid and (st_reg.shift == 5'h00)) |=> cap)
		else $error("no capture on edge after sync");

	a_dclk_on_sync: assert property (
		s_sync_valid |=> data_clock_out && !$past(st_reg.dclk, 1) ||
			div_mask == 5'h00 || $past(div_mask, 1) == 5'h00)
		else $error("data clock did not rise after sync");

	a_capture_period4: assert property (
		(cap && div_log == 3'h2 && !sync_rise && !reg_req.wr) ##1 s_quiet3
			|=> cap)
		else $error("capture spacing not four cycles");

	a_invalid_quiet: assert property (
		invalid ##1 invalid |-> !cap && !data_clock_out)
		else $error("activity in invalid mode");

	a_div_bound: assert property (
		div_log <= MAX_DIV_LOG)
		else $error("divisor above 32");

	a_extra_div3: assert property (
		st_reg.extra_div == 2'h3 && st_reg.mode == 4'h0 |-> div_log == 3'h0)
		else $error("extra divide code 11 not by one");

	a_fine_off: assert property (
		st_reg.fine_dis |=> fine_delay_taps == 5'h00)
		else $error("fine delay active while disabled");

	a_fine_linear: assert property (
		!st_reg.fine_dis |=> fine_delay_taps ==
			{1'b0, $past(st_reg.fine_code)} + 5'h01)
		else $error("fine delay tap not code plus one");

	a_ovf_sticky: assert property (
		cap && !fifo_in_ready |=> st_reg.ovf)
		else $error("lost word not flagged");

endmodule : idca_align

// ==== rtl/idca_fifo.sv ====
// Small synchronous FIFO between the capture logic and the converter.
// Assumes one clock; the drain side may stall so the FIFO really fills.
`timescale 1ns/1ps
module idca_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Filling side.
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Draining side.
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} idca_fifo_s;

	idca_fifo_s fifo_reg;
	idca_fifo_s fifo_next;
	logic push;
	logic pop;

	assign in_ready = (fifo_reg.cnt != (PW+1)'(D));
	assign out_valid = (fifo_reg.cnt != '0);
	assign out_data = fifo_reg.mem[fifo_reg.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		fifo_next = fifo_reg;
		if (push) begin
			fifo_next.mem[fifo_reg.wp] = in_data;
			fifo_next.wp = fifo_reg.wp + 1'b1;
		end
		if (pop) begin
			fifo_next.rp = fifo_reg.rp + 1'b1;
		end
		fifo_next.cnt = fifo_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			fifo_reg <= '0;
		end else begin
			fifo_reg <= fifo_next;
		end
	end

endmodule : idca_fifo

// ==== sim/idca_src.sv ====
// Model of the data source that sits in front of the align block.
// Assumes the bench calls pulse_sync right after a rising mclk edge.
`timescale 1ns/1ps
module idca_src (
	// Clock.
	input wire logic mclk,
	// Pins towards the block.
	output logic sync_in,
	output logic [idca_pkg::DATA_W-1:0] data_in
);
	import idca_pkg::*;
	initial sync_in = 1'b0;
	initial data_in = 16'h0000;
	// The data change every cycle, so a stale capture never passes as new.
	always @(posedge mclk) begin
		data_in <= data_in + 16'h0001;
	end
	// Sync rises only on command, so the bench picks its rate and phase.
	task automatic pulse_sync(input int n);
		sync_in <= 1'b1;
		repeat (n) @(posedge mclk);
		sync_in <= 1'b0;
	endtask : pulse_sync
endmodule : idca_src

// ==== sim/tb.sv ====
// Self-checking bench for the data clock alignment block.
// Assumes the source model drives the pins; the bench owns the registers.
`timescale 1ns/1ps
module tb;
	import idca_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	idca_reg_req_s reg_req = '0;
	logic [7:0] reg_rdata;
	logic sync_in;
	logic dclk;
	logic sample_ready = 1'b1;
	logic [DATA_W-1:0] data_in;
	logic [4:0] taps;
	idca_word_s sample_out;
	int n_mismatch = 0;
	int n_compared = 0;

	always #10 mclk = ~mclk;

	idca_align DUT (.mclk(mclk), .nrst(nrst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .sync_in(sync_in), .data_in(data_in),
		.data_clock_out(dclk), .fine_delay_taps(taps),
		.sample_out(sample_out), .sample_ready(sample_ready));
	idca_src u_src (.mclk(mclk), .sync_in(sync_in), .data_in(data_in));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		reg_req.wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp,
		input logic [7:0] msk);
		@(posedge mclk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		reg_req.rd <= 1'b0;
		#1 check(reg_rdata & msk, exp);
	endtask : rdchk

	// Bit 3 flags the invalid mode, bits 2:0 give the log2 of the divisor.
	function automatic logic [3:0] exp_div(input int m, input int x);
		int b;
		b = (m & 3) + ((m & 12) == 4) - ((m & 12) == 8);
		if ((m & 15) == 8) return 4'h8;
		b = b + ((x == 1) ? 1 : (x == 2) ? 2 : 0);
		return (b > 5) ? 4'h5 : 4'(b);
	endfunction : exp_div

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdchk(REG_STATUS, 8'h00, 8'hFF);
		rdchk(REG_DCLK_CTRL, RST_DCLK_CTRL, 8'hFF);
		rdchk(REG_DCLK_DIV, 8'h00, 8'hFF);
		rdchk(REG_FINE_DELAY, 8'h00, 8'hFF);
		rdchk(REG_MODE, 8'h00, 8'hFF);
		wr(8'h55, 8'hFF);
		rdchk(8'h55, 8'h00, 8'hFF);
		wr(REG_SHIFT, 8'h1F);
		rdchk(REG_SHIFT, 8'h1F, 8'hFF);
		wr(REG_SHIFT, 8'h00);
	endtask : t_reset

	task automatic t_divisors;
		logic [3:0] e;
		for (int m = 0; m < 16; m++) begin
			for (int x = 0; x < 4; x++) begin
				e = exp_div(m, x);
				wr(REG_DCLK_DIV, 8'(x << 4));
				wr(REG_MODE, 8'(m));
				rdchk(REG_STATUS, {4'h0, e}, e[3] ? 8'h28 : 8'h2F);
			end
		end
		wr(REG_DCLK_DIV, 8'h00);
	endtask : t_divisors

	task automatic t_fine;
		wr(REG_DCLK_CTRL, 8'h10);
		repeat (2) @(posedge mclk);
		#1 check({3'h0, taps}, 8'h00);
		wr(REG_DCLK_CTRL, 8'h00);
		for (int c = 0; c < 16; c++) begin
			wr(REG_FINE_DELAY, 8'(c << 4));
			repeat (2) @(posedge mclk);
			#1 check({3'h0, taps}, 8'(c + 1));
		end
	endtask : t_fine

	// Divisor 4: the clock is pulled low at the third edge, then is high
	// for two cycles from the fourth edge.
	task automatic t_sync;
		wr(REG_MODE, 8'h02);
		repeat (9) @(posedge mclk);
		u_src.pulse_sync(3);
		#1 check({7'h0, dclk}, 8'h00);
		@(posedge mclk);
		for (int k = 0; k < 8; k++) begin
			#1 check({7'h0, dclk}, {7'h0, (k % 4) < 2});
			@(posedge mclk);
		end
		rdchk(REG_STATUS, 8'h22, 8'h2F);
	endtask : t_sync

	task automatic t_fifo;
		int n;
		logic [DATA_W-1:0] prev;
		n = 0;
		prev = '0;
		@(posedge mclk);
		sample_ready <= 1'b0;
		wr(REG_MODE, 8'h00);
		repeat (12) @(posedge mclk);
		// The invalid mode stops capture, so the clear below can stick.
		wr(REG_MODE, 8'h08);
		rdchk(REG_STATUS, 8'h18, 8'h18);
		#1 check({7'h0, dclk}, 8'h00);
		wr(REG_STATUS, 8'h10);
		rdchk(REG_STATUS, 8'h08, 8'h18);
		@(posedge mclk);
		sample_ready <= 1'b1;
		for (int k = 0; k < 20; k++) begin
			// Words leave in capture order, so each is newer than the last.
			#1 if (sample_out.valid === 1'b1) begin
				if (n > 0) begin
					check({7'h0, sample_out.data > prev}, 8'h01);
				end
				prev = sample_out.data;
				n++;
			end
			@(posedge mclk);
		end
		check(8'(n), 8'h08);
		#1 check({7'h0, sample_out.valid}, 8'h00);
	endtask : t_fifo

	task automatic tally_and_finish;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		t_reset();
		t_divisors();
		t_fine();
		t_sync();
		t_fifo();
		tally_and_finish();
	end
endmodule : tb
